// file: include/lsc_pkg.sv
// Constants, field layouts and state types of the low-speed link handler.
// Assumes a 20 MHz pclk; shared by the handler and its bench.
package lsc_pkg;
  // Command codes arriving from the module application.
  localparam logic [7:0] CMD_CONNECT = 8'h01;
  localparam logic [7:0] CMD_DISC = 8'h02;
  localparam logic [7:0] CMD_SETP = 8'h03;
  localparam logic [7:0] CMD_ENQ = 8'h04;
  localparam logic [7:0] CMD_GNB = 8'h05;
  // Reply codes of acknowledge objects.
  localparam logic [7:0] RC_CONNECT = 8'h01;
  localparam logic [7:0] RC_DISC = 8'h02;
  localparam logic [7:0] RC_SETP = 8'h03;
  localparam logic [7:0] RC_STATUS = 8'h04;
  localparam logic [7:0] RC_GNB = 8'h05;
  localparam logic [7:0] RC_SEND = 8'h06;
  // Signed return values.
  localparam logic [7:0] RV_OK = 8'h00;
  localparam logic [7:0] RV_CONN = 8'h01;
  localparam logic [7:0] RV_ERR = 8'hFF;
  localparam logic [7:0] MAX_BUF = 8'hFE;
  localparam logic [7:0] BUFSZ_RST = 8'hFE;
  localparam logic [7:0] TOUT_RST = 8'h01;
  // Resource identifier layout.
  localparam logic [15:0] RID_CLASS = 16'h0060;
  localparam logic [5:0] RID_VER = 6'h01;
  localparam int TYPE_DEV_LSB = 2;
  localparam logic [7:0] DEV_MODEM_MAX = 8'h3F;
  localparam logic [7:0] DEV_CABLE = 8'h50;
  localparam logic [1:0] DP_NEG = 2'b00;
  localparam logic [1:0] DP_NOCOMP = 2'b01;
  localparam logic [1:0] DP_NONE = 2'b10;
  localparam logic [9:0] TYPE_RST = 10'h000;
  // Register byte offsets and bit positions.
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_RID = 12'h004;
  localparam logic [11:0] A_STAT = 12'h008;
  localparam logic [11:0] A_QRY = 12'h00C;
  localparam int INUSE_BIT = 16;
  localparam int BUSY_BIT = 16;
  // Receive timeout unit.
  localparam int TO_UNIT_NS = 10000000;
  localparam int CLK_NS = 50;
  localparam int TO_UNIT_CYC = TO_UNIT_NS / CLK_NS;
  typedef enum logic [2:0] {
    OB_IDLE = 3'b001,
    OB_TAKE = 3'b010,
    OB_DROP = 3'b100
  } lsc_ob_e;
  typedef enum logic [1:0] {
    RX_FILL = 2'b01,
    RX_OUT = 2'b10
  } lsc_rx_e;
endpackage

// file: design/lsc_handler.sv
// Host side handler of low-speed link objects with an APB register slave.
// Assumes object tags and lengths are stripped upstream and that the line
// device talks ready/valid on pclk; line_up is an asynchronous pin.
//
// Contract
// - Acknowledge carries reply code 01..06 and an 8-bit return value.
// - Return values are signed: zero success, -1 generic error.
// - Status enquiry returns 0 when disconnected, 1 when connected.
// - Transmit acknowledge value names the phase of the sent buffer.
// - Outbound phases start at 0 after connect, then alternate.
// - Host holds just two outbound buffers: sending and waiting.
// - Host may send acknowledges unasked when an error occurs.
// - Line drop sends unsolicited status reply with value 0.
// - Broken phase alternation gets a transmit acknowledge error.
// - Outbound object is phase byte then message bytes.
// - Inbound object is phase byte then bytes; phase names request.
// - Resource identifier is class 96, type in middle, version 1.
// - Type bits 0 and 1 hold the device instance number.
// - Type bits 2 to 9: modems 00-3F, serial 40-4F, cable 50.
// - Modem data-processing: negotiate, no compression, none.
// - Negotiate tries correction and compression; other only correction. Here none (DP_NONE) enables neither.
// - Four-bit modem field codes the standard; unlisted codes reserved.
// - Each modem speed is presented as its own resource type.
// - One modem type in use makes its other types read busy.
// - First receive request has phase 0, then alternating, two at most.
// - Partly filled inbound buffer leaves after the timeout of 10 ms units.
// - Full inbound buffer leaves at once.
`timescale 1ns/1ns
module lsc_handler #(
  parameter int TICK_CYC = lsc_pkg::TO_UNIT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_arg0,
  input wire logic [7:0] cmd_arg1,
  input wire logic ob_valid,
  output logic ob_ready,
  input wire logic ob_first,
  input wire logic ob_last,
  input wire logic [7:0] ob_data,
  output logic rep_valid,
  input wire logic rep_ready,
  output logic [7:0] reply_code,
  output logic [7:0] rep_value,
  input wire logic line_up,
  output logic line_dial,
  output logic line_tx_valid,
  input wire logic line_tx_ready,
  output logic [7:0] line_tx_data,
  input wire logic line_rx_valid,
  output logic line_rx_ready,
  input wire logic [7:0] line_rx_data,
  output logic ib_valid,
  input wire logic ib_ready,
  output logic ib_first,
  output logic ib_last,
  output logic [7:0] ib_data,
  output logic modem_ec_en,
  output logic modem_comp_en,
  output logic [3:0] modem_std
);
  import lsc_pkg::*;

  // Device type codes that fall in the modem range.
  function automatic logic is_modem(input logic [9:0] t);
    return t[9:TYPE_DEV_LSB] <= DEV_MODEM_MAX;
  endfunction

  // Modem standards with an assigned code.
  function automatic logic std_ok(input logic [3:0] s);
    return !(s inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hB, 4'hC, 4'hD});
  endfunction

  logic s1_r, s2_r, s3_r, up_r;
  logic [9:0] type_r, qry_r;
  logic in_use_r, dial_r;
  logic [7:0] bufsz_r, tout_r;
  logic rep_valid_r;
  logic [7:0] rep_code_r, rep_val_r;
  logic disc_pend_r, serr_pend_r, sok_pend_r, sok_val_r;
  lsc_ob_e ob_st_r;
  lsc_rx_e rx_st_r;
  logic [1:0] slot_full_r, slot_ph_r;
  logic [7:0] slot_len_r [0:1];
  logic [7:0] ob_mem_r [0:1][0:253];
  logic wr_slot_r, rd_slot_r, exp_ph_r;
  logic [7:0] ob_idx_r, tx_idx_r;
  logic gnb_exp_r, dlv_ph_r;
  logic [1:0] gnb_cnt_r;
  logic [7:0] rx_mem_r [0:253];
  logic [7:0] rx_cnt_r, rx_idx_r, unit_r;
  logic [17:0] tick_r;
  logic rep_free, take_disc, take_err, take_ok, cmd_take, cmd_known;
  logic [7:0] cmd_rc, cmd_rv;
  logic connect, gnb_ok, gnb_take, tx_done, first_ok, ob_end;
  logic rx_take, dlv_start, dlv_end, wr_en, rd_en;

  // Line state passes three flops; a change counts once the last two agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      up_r <= 1'b0;
    end else begin
      s1_r <= line_up;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        up_r <= s3_r;
      end
    end
  end

  // APB slave answers in the access cycle with no wait states.
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  // Register writes: control type, in-use flag and busy query.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      type_r <= TYPE_RST;
      in_use_r <= 1'b0;
      qry_r <= TYPE_RST;
    end else if (wr_en && paddr == A_CTRL) begin
      type_r <= pwdata[9:0];
      in_use_r <= pwdata[INUSE_BIT];
    end else if (wr_en && paddr == A_QRY) begin
      qry_r <= pwdata[9:0];
    end
  end

  // Read mux; an unmapped address answers zero with pslverr.
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (paddr == A_CTRL) begin
      prdata[9:0] = type_r;
      prdata[INUSE_BIT] = in_use_r;
    end else if (paddr == A_RID) begin
      prdata = {RID_CLASS, type_r, RID_VER};
    end else if (paddr == A_STAT) begin
      prdata[7:0] = {dial_r, up_r, exp_ph_r, gnb_exp_r, gnb_cnt_r,
                     slot_full_r};
      prdata[8] = type_r[9:TYPE_DEV_LSB] > DEV_CABLE ||
                  (is_modem(type_r) && (type_r[7:6] == 2'b11 ||
                   !std_ok(type_r[5:2])));
    end else if (paddr == A_QRY) begin
      prdata[9:0] = qry_r;
      prdata[BUSY_BIT] = in_use_r && is_modem(qry_r) &&
                         is_modem(type_r) && qry_r != type_r &&
                         qry_r[1:0] == type_r[1:0];
    end else begin
      pslverr = psel && penable;
    end
  end

  // standard and data-processing bits, modem decode
  // Each speed is its own type, so the line device follows the type field.
  assign modem_std = is_modem(type_r) ? type_r[5:2] : 4'h0;
  assign modem_ec_en = is_modem(type_r) &&
                       (type_r[7:6] == DP_NEG || type_r[7:6] == DP_NOCOMP);
  assign modem_comp_en = is_modem(type_r) && type_r[7:6] == DP_NEG;

  // Reply slot arbitration; the line drop outranks every other answer.
  assign rep_free = !rep_valid_r || rep_ready;
  assign take_disc = rep_free && disc_pend_r;
  assign take_err = rep_free && !disc_pend_r && serr_pend_r;
  assign take_ok = rep_free && !disc_pend_r && !serr_pend_r && sok_pend_r;
  assign cmd_ready = rep_free && !disc_pend_r && !serr_pend_r &&
                     !sok_pend_r;
  assign cmd_take = cmd_valid && cmd_ready;
  assign connect = cmd_take && cmd_code == CMD_CONNECT;
  assign gnb_ok = cmd_arg0 == {7'h00, gnb_exp_r} && gnb_cnt_r != 2'd2;
  assign gnb_take = cmd_take && cmd_code == CMD_GNB && gnb_ok;

  // reply code and signed value per command
  always_comb begin
    cmd_known = 1'b1;
    cmd_rc = RC_CONNECT;
    cmd_rv = RV_OK;
    case (cmd_code)
      CMD_CONNECT: cmd_rc = RC_CONNECT;
      CMD_DISC: cmd_rc = RC_DISC;
      CMD_SETP: begin
        cmd_rc = RC_SETP;
        if (cmd_arg0 == 8'h00 || cmd_arg0 > MAX_BUF) begin
          cmd_rv = RV_ERR;
        end
      end
      CMD_ENQ: begin
        cmd_rc = RC_STATUS;
        cmd_rv = up_r ? RV_CONN : RV_OK;
      end
      CMD_GNB: begin
        cmd_rc = RC_GNB;
        cmd_rv = gnb_ok ? RV_OK : RV_ERR;
      end
      default: cmd_known = 1'b0;
    endcase
  end

  // Reply register; it holds until the application takes it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rep_valid_r <= 1'b0;
      rep_code_r <= 8'h00;
      rep_val_r <= 8'h00;
    end else if (take_disc) begin
      rep_valid_r <= 1'b1;
      rep_code_r <= RC_STATUS;
      rep_val_r <= RV_OK;
    end else if (take_err || take_ok) begin
      // transmit acknowledge with phase or error
      rep_valid_r <= 1'b1;
      rep_code_r <= RC_SEND;
      rep_val_r <= take_err ? RV_ERR : {7'h00, sok_val_r};
    end else if (cmd_take && cmd_known) begin
      rep_valid_r <= 1'b1;
      rep_code_r <= cmd_rc;
      rep_val_r <= cmd_rv;
    end else if (rep_ready) begin
      rep_valid_r <= 1'b0;
    end
  end
  assign rep_valid = rep_valid_r;
  assign reply_code = rep_code_r;
  assign rep_value = rep_val_r;

  // Pending unsolicited answers; a new event beats a same-cycle take.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disc_pend_r <= 1'b0;
      serr_pend_r <= 1'b0;
      sok_pend_r <= 1'b0;
      sok_val_r <= 1'b0;
    end else begin
      disc_pend_r <= (up_r && s2_r == s3_r && !s3_r) ||
                     (disc_pend_r && !take_disc);
      serr_pend_r <= (ob_valid && ob_first && !first_ok) ||
                     (serr_pend_r && !take_err);
      sok_pend_r <= tx_done || (sok_pend_r && !take_ok);
      if (tx_done) begin
        sok_val_r <= slot_ph_r[rd_slot_r];
      end
    end
  end

  // Session parameters and dial request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bufsz_r <= BUFSZ_RST;
      tout_r <= TOUT_RST;
      dial_r <= 1'b0;
    end else if (cmd_take && cmd_code == CMD_SETP && cmd_rv == RV_OK) begin
      bufsz_r <= cmd_arg0;
      tout_r <= cmd_arg1;
    end else if (connect) begin
      dial_r <= 1'b1;
    end else if (cmd_take && cmd_code == CMD_DISC) begin
      dial_r <= 1'b0;
    end
  end
  assign line_dial = dial_r;

  // first byte must match, slot free
  assign first_ok = ob_data == {7'h00, exp_ph_r} &&
                    !slot_full_r[wr_slot_r];
  assign ob_ready = 1'b1;
  assign ob_end = ob_valid && ob_last && ob_st_r == OB_TAKE;

  // Outbound intake; a rejected object is swallowed up to its last byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ob_st_r <= OB_IDLE;
      ob_idx_r <= 8'h00;
      exp_ph_r <= 1'b0;
      wr_slot_r <= 1'b0;
    end else if (connect) begin
      ob_st_r <= OB_IDLE;
      exp_ph_r <= 1'b0;
      wr_slot_r <= 1'b0;
    end else if (ob_valid) begin
      case (ob_st_r)
        OB_IDLE: begin
          if (ob_first) begin
            ob_idx_r <= 8'h00;
            ob_st_r <= first_ok ? OB_TAKE : OB_DROP;
            // A single-beat object ends here, taken or refused, so the
            // first beat of the next object is never swallowed.
            if (ob_last) begin
              ob_st_r <= OB_IDLE;
            end
          end
        end
        OB_TAKE: begin
          if (ob_idx_r < MAX_BUF) begin
            ob_idx_r <= ob_idx_r + 8'h01;
          end
          if (ob_last) begin
            ob_st_r <= OB_IDLE;
          end
        end
        default: begin
          if (ob_last || ob_first) begin
            ob_st_r <= OB_IDLE;
          end
        end
      endcase
      if (ob_end || (ob_st_r == OB_IDLE && ob_first && first_ok)) begin
        if (ob_end || ob_last) begin
          exp_ph_r <= !exp_ph_r;
          wr_slot_r <= !wr_slot_r;
        end
      end
    end
  end

  // Buffer storage has no reset; slot flags say what is valid.
  always_ff @(posedge pclk) begin
    if (ob_valid && ob_st_r == OB_TAKE && ob_idx_r < MAX_BUF) begin
      ob_mem_r[wr_slot_r][ob_idx_r] <= ob_data;
    end
    if (rx_take) begin
      rx_mem_r[rx_cnt_r] <= line_rx_data;
    end
  end

  // two slots: one on the line, one waiting.
  // A finished slot waits for its acknowledge to leave before the next.
  assign tx_done = slot_full_r[rd_slot_r] && !sok_pend_r &&
                   tx_idx_r == slot_len_r[rd_slot_r];
  assign line_tx_valid = slot_full_r[rd_slot_r] && !sok_pend_r &&
                         tx_idx_r != slot_len_r[rd_slot_r];
  assign line_tx_data = ob_mem_r[rd_slot_r][tx_idx_r];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_full_r <= 2'b00;
      slot_ph_r <= 2'b00;
      slot_len_r[0] <= 8'h00;
      slot_len_r[1] <= 8'h00;
      rd_slot_r <= 1'b0;
      tx_idx_r <= 8'h00;
    end else if (connect) begin
      slot_full_r <= 2'b00;
      rd_slot_r <= 1'b0;
      tx_idx_r <= 8'h00;
    end else begin
      if (ob_valid && ob_last && (ob_st_r == OB_TAKE ||
          (ob_st_r == OB_IDLE && ob_first && first_ok))) begin
        slot_full_r[wr_slot_r] <= 1'b1;
        slot_ph_r[wr_slot_r] <= exp_ph_r;
        slot_len_r[wr_slot_r] <= ob_st_r == OB_TAKE &&
                                 ob_idx_r < MAX_BUF ?
                                 ob_idx_r + 8'h01 : ob_idx_r;
      end
      if (tx_done) begin
        slot_full_r[rd_slot_r] <= 1'b0;
        rd_slot_r <= !rd_slot_r;
        tx_idx_r <= 8'h00;
      end else if (line_tx_valid && line_tx_ready) begin
        tx_idx_r <= tx_idx_r + 8'h01;
      end
    end
  end

  // delivery on full buffer or idle timeout
  assign rx_take = line_rx_valid && line_rx_ready;
  assign line_rx_ready = rx_st_r == RX_FILL && rx_cnt_r < bufsz_r;
  assign dlv_start = rx_st_r == RX_FILL && rx_cnt_r != 8'h00 &&
                     gnb_cnt_r != 2'd0 &&
                     (rx_cnt_r >= bufsz_r || unit_r >= tout_r);
  assign dlv_end = ib_valid && ib_ready && ib_last;
  // phase beat first, then the received bytes
  assign ib_valid = rx_st_r == RX_OUT;
  assign ib_first = rx_idx_r == 8'h00;
  assign ib_last = rx_idx_r == rx_cnt_r;
  assign ib_data = ib_first ? {7'h00, dlv_ph_r} :
                   rx_mem_r[rx_idx_r - 8'h01];

  // Inbound fill, idle timer in 10 ms units, and delivery.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_r <= RX_FILL;
      rx_cnt_r <= 8'h00;
      rx_idx_r <= 8'h00;
      tick_r <= 18'h00000;
      unit_r <= 8'h00;
    end else if (connect) begin
      rx_st_r <= RX_FILL;
      rx_cnt_r <= 8'h00;
    end else begin
      case (rx_st_r)
        RX_FILL: begin
          if (rx_take) begin
            rx_cnt_r <= rx_cnt_r + 8'h01;
            tick_r <= 18'h00000;
            unit_r <= 8'h00;
          end else if (tick_r == 18'(TICK_CYC - 1)) begin
            tick_r <= 18'h00000;
            if (unit_r != 8'hFF) begin
              unit_r <= unit_r + 8'h01;
            end
          end else begin
            tick_r <= tick_r + 18'h00001;
          end
          if (dlv_start) begin
            rx_st_r <= RX_OUT;
            rx_idx_r <= 8'h00;
          end
        end
        default: begin
          if (ib_ready) begin
            rx_idx_r <= rx_idx_r + 8'h01;
          end
          if (dlv_end) begin
            rx_st_r <= RX_FILL;
            rx_cnt_r <= 8'h00;
            tick_r <= 18'h00000;
            unit_r <= 8'h00;
          end
        end
      endcase
    end
  end

  // request credit: at most two outstanding.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gnb_exp_r <= 1'b0;
      dlv_ph_r <= 1'b0;
      gnb_cnt_r <= 2'd0;
    end else if (connect) begin
      gnb_exp_r <= 1'b0;
      dlv_ph_r <= 1'b0;
      gnb_cnt_r <= 2'd0;
    end else begin
      if (gnb_take) begin
        gnb_exp_r <= !gnb_exp_r;
      end
      if (dlv_end) begin
        dlv_ph_r <= !dlv_ph_r;
      end
      gnb_cnt_r <= gnb_cnt_r + {1'b0, gnb_take} - {1'b0, dlv_end};
    end
  end

  property p_code_range;
    @(posedge pclk) disable iff (!presetn)
    rep_valid |-> reply_code >= RC_CONNECT && reply_code <= RC_SEND;
  endproperty
  a_code_range: assert property (p_code_range)
    else $error("reply code out of range");

  property p_enq;
    @(posedge pclk) disable iff (!presetn)
    cmd_take && cmd_code == CMD_ENQ |=> reply_code == RC_STATUS &&
      rep_value == {7'h00, $past(up_r)};
  endproperty
  a_enq: assert property (p_enq)
    else $error("status reply value wrong");

  property p_disc;
    @(posedge pclk) disable iff (!presetn)
    $fell(up_r) && !rep_valid |=> rep_valid &&
      reply_code == RC_STATUS && rep_value == RV_OK;
  endproperty
  a_disc: assert property (p_disc)
    else $error("no disconnect report");

  property p_ack_phase;
    @(posedge pclk) disable iff (!presetn)
    take_ok |=> reply_code == RC_SEND &&
      rep_value == {7'h00, $past(sok_val_r)};
  endproperty
  a_ack_phase: assert property (p_ack_phase)
    else $error("send ack phase wrong");

  property p_seq;
    @(posedge pclk) disable iff (!presetn)
    ob_valid && ob_first && ob_st_r == OB_IDLE && !connect &&
      ob_data != {7'h00, exp_ph_r} |=>
      ob_st_r == ($past(ob_last) ? OB_IDLE : OB_DROP) ##0 serr_pend_r;
  endproperty
  a_seq: assert property (p_seq)
    else $error("phase break not refused");

  property p_full;
    @(posedge pclk) disable iff (!presetn)
    ob_valid && ob_first && &slot_full_r && !connect |=> serr_pend_r;
  endproperty
  a_full: assert property (p_full)
    else $error("third buffer accepted");

  property p_gnb;
    @(posedge pclk) disable iff (!presetn)
    gnb_cnt_r != 2'd3 and (connect |=> gnb_exp_r == 1'b0);
  endproperty
  a_gnb: assert property (p_gnb)
    else $error("receive request credit broken");

  property p_full_dlv;
    @(posedge pclk) disable iff (!presetn)
    rx_st_r == RX_FILL && rx_cnt_r == bufsz_r && gnb_cnt_r != 2'd0 &&
      !connect |=> ib_valid && ib_first && ib_data == {7'h00, dlv_ph_r};
  endproperty
  a_full_dlv: assert property (p_full_dlv)
    else $error("full buffer not delivered");

  c_send: cover property (@(posedge pclk) disable iff (!presetn) take_ok);
  c_err: cover property (@(posedge pclk) disable iff (!presetn) take_err);
  c_dlv: cover property (@(posedge pclk) disable iff (!presetn) dlv_end);
endmodule

// file: sim/lsc_line_model.sv
// Behavioural line device facing the handler's line ports.
// Assumes the handler's pclk; drop pulls the line down on purpose.
`timescale 1ns/1ns
module lsc_line_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic drop,
  input wire logic line_dial,
  input wire logic line_tx_valid,
  input wire logic [7:0] line_tx_data,
  input wire logic line_rx_ready,
  input wire logic rx_go,
  input wire logic [7:0] rx_n,
  output logic line_up,
  output logic line_tx_ready,
  output logic line_rx_valid,
  output logic [7:0] line_rx_data,
  output logic [7:0] tx_count,
  output logic [7:0] tx_last
);
  logic [7:0] rx_left_r;
  // The line follows dialling; it takes a byte only every other cycle,
  // so the handler always meets a slow line.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_up <= 1'b0;
      line_tx_ready <= 1'b0;
      tx_count <= 8'h00;
      tx_last <= 8'h00;
    end else begin
      line_up <= line_dial & ~drop;
      line_tx_ready <= ~line_tx_ready;
      if (line_tx_valid && line_tx_ready) begin
        tx_count <= tx_count + 8'h01;
        tx_last <= line_tx_data;
      end
    end
  end
  // A start pulse offers rx_n bytes counting up from C0; each byte holds
  // until the handler takes it, as a real line buffer would.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_left_r <= 8'h00;
      line_rx_data <= 8'h00;
    end else if (rx_go) begin
      rx_left_r <= rx_n;
      line_rx_data <= 8'hC0;
    end else if (line_rx_valid && line_rx_ready) begin
      rx_left_r <= rx_left_r - 8'h01;
      line_rx_data <= line_rx_data + 8'h01;
    end
  end
  assign line_rx_valid = rx_left_r != 8'h00;
endmodule

// file: sim/lsc_handler_tb_top.sv
// Self-checking bench of the low-speed link handler.
// Assumes lsc_pkg is compiled first and the line model stands beside it.
`timescale 1ns/1ns
module lsc_handler_tb_top;
  import lsc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, cmd_valid = 1'b0, rep_ready = 1'b1, drop = 1'b0;
  logic ob_valid = 1'b0, ob_first = 1'b0, ob_last = 1'b0, ib_ready = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] cmd_code = 8'h00, cmd_arg0 = 8'h00, cmd_arg1 = 8'h00;
  logic [7:0] ob_data = 8'h00, reply_code, rep_value, line_tx_data;
  logic [7:0] line_rx_data, ib_data, tx_count;
  logic pready, pslverr, cmd_ready, rep_valid, ob_ready, line_up, err;
  logic line_dial, line_tx_valid, line_tx_ready, line_rx_valid;
  logic line_rx_ready, ib_valid, ib_first, ib_last, modem_ec_en;
  logic modem_comp_en;
  logic [3:0] modem_std;
  logic [15:0] rq[$], iq[$];
  logic rx_go = 1'b0;
  logic [7:0] rx_n = 8'h00, tx_last;
  int n_fail = 0, check_count = 0;

  lsc_handler #(.TICK_CYC(20)) dut (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .cmd_valid,
    .cmd_ready, .cmd_code, .cmd_arg0, .cmd_arg1, .ob_valid, .ob_ready,
    .ob_first, .ob_last, .ob_data, .rep_valid, .rep_ready, .reply_code,
    .rep_value, .line_up, .line_dial, .line_tx_valid, .line_tx_ready,
    .line_tx_data, .line_rx_valid, .line_rx_ready, .line_rx_data,
    .ib_valid, .ib_ready, .ib_first, .ib_last, .ib_data, .modem_ec_en,
    .modem_comp_en, .modem_std);
  lsc_line_model u_line (.pclk, .presetn, .drop, .line_dial,
    .line_tx_valid, .line_tx_data, .line_rx_ready, .rx_go, .rx_n,
    .line_up, .line_tx_ready, .line_rx_valid, .line_rx_data, .tx_count,
    .tx_last);

  // Free-running 20 MHz clock.
  always #25 pclk = ~pclk;
  // Replies and inbound beats are collected at the falling edge.
  always @(negedge pclk) begin
    if (rep_valid === 1'b1 && rep_ready === 1'b1) begin
      rq.push_back({reply_code, rep_value});
    end
    if (ib_valid === 1'b1 && ib_ready === 1'b1) begin
      iq.push_back({6'h00, ib_first, ib_last, ib_data});
    end
  end

  task automatic summarize;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // A wait that runs out ends the run as a failure.
  task automatic hang;
    n_fail++;
    summarize();
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Data and error are taken at the edge that sees pready high.
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 50) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] a0);
    int i;
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_arg0 <= a0;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (cmd_ready === 1'b1) break;
    end
    if (i == 50) hang();
    cmd_valid <= 1'b0;
  endtask
  // Pops a reply, or an inbound beat when ib is set.
  task automatic get_rep(input logic [15:0] exp, input bit ib = 1'b0);
    int i;
    for (i = 0; i < 400 && (ib ? iq.size() : rq.size()) == 0; i++)
      @(posedge pclk);
    if ((ib ? iq.size() : rq.size()) == 0) hang();
    check(ib ? iq.pop_front() : rq.pop_front(), exp);
  endtask
  // One outbound object: a phase beat, then n message bytes.
  // callers keep n at 254 or below
  task automatic ob_send(input logic [7:0] ph, input int n);
    for (int i = 0; i <= n; i++) begin
      ob_valid <= 1'b1;
      ob_first <= (i == 0);
      ob_last <= (i == n);
      ob_data <= (i == 0) ? ph : 8'hA0 + 8'(i);
      @(posedge pclk);
    end
    ob_valid <= 1'b0;
  endtask

  task automatic t_regs;
    check({modem_ec_en, modem_comp_en, modem_std}, 6'h30);
    apb(1'b1, A_CTRL, 32'h0000_0151);
    apb(1'b0, A_STAT, 32'h0);
    check(rd[8], 1'b1);
    apb(1'b1, A_CTRL, 32'h0000_0141);
    apb(1'b0, A_RID, 32'h0);
    check(rd, 32'h0060_5041);
    check(rd[7:6], 2'b01);
    apb(1'b1, A_CTRL, 32'h0001_0008);
    check({modem_ec_en, modem_comp_en, modem_std}, 6'h32);
    apb(1'b1, A_QRY, 32'h0000_0028);
    apb(1'b0, A_QRY, 32'h0);
    check(rd[16], 1'b1);
    apb(1'b1, A_QRY, 32'h0000_0029);
    apb(1'b0, A_QRY, 32'h0);
    check(rd[16], 1'b0);
    apb(1'b0, 12'h010, 32'h0);
    check({err, rd[7:0]}, 9'h100);
    $display("t_regs done");
  endtask
  task automatic t_link;
    cmd(CMD_ENQ, 8'h00);
    get_rep(16'h0400);
    cmd(CMD_CONNECT, 8'h00);
    get_rep(16'h0100);
    repeat (6) @(posedge pclk);
    cmd(CMD_ENQ, 8'h00);
    get_rep(16'h0401);
    cmd(CMD_GNB, 8'h01);
    get_rep(16'h05FF);
    $display("t_link done");
  endtask
  task automatic t_send;
    ob_send(8'h00, 2);
    get_rep(16'h0600);
    check(tx_count, 8'h02);
    check(tx_last, 8'hA2);
    ob_send(8'h01, 1);
    get_rep(16'h0601);
    ob_send(8'h01, 1);
    get_rep(16'h06FF);
    ob_send(8'h00, 8);
    @(posedge pclk);
    ob_send(8'h01, 8);
    @(posedge pclk);
    ob_send(8'h00, 1);
    get_rep(16'h06FF);
    get_rep(16'h0600);
    get_rep(16'h0601);
    check(tx_count, 8'h13);
    $display("t_send done");
  endtask
  // Size 3, timeout 2 units: first buffer leaves full, second on timeout.
  task automatic t_rcv;
    cmd_arg1 <= 8'h02;
    cmd(CMD_SETP, 8'h00);
    get_rep(16'h03FF);
    cmd(CMD_SETP, 8'h03);
    get_rep(16'h0300);
    rx_n <= 8'h05;
    rx_go <= 1'b1;
    @(posedge pclk);
    rx_go <= 1'b0;
    cmd(CMD_GNB, 8'h00);
    get_rep(16'h0500);
    get_rep(16'h0200, 1'b1);
    get_rep(16'h00C0, 1'b1);
    get_rep(16'h00C1, 1'b1);
    get_rep(16'h01C2, 1'b1);
    cmd(CMD_GNB, 8'h01);
    get_rep(16'h0500);
    repeat (20) @(posedge pclk);
    check(iq.size(), 0);
    get_rep(16'h0201, 1'b1);
    get_rep(16'h00C3, 1'b1);
    get_rep(16'h01C4, 1'b1);
    $display("t_rcv done");
  endtask
  task automatic t_drop;
    drop <= 1'b1;
    get_rep(16'h0400);
    cmd(CMD_ENQ, 8'h00);
    get_rep(16'h0400);
    $display("t_drop done");
  endtask

  // Reset for three cycles, then the scenarios in turn.
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_link();
    t_send();
    t_rcv();
    t_drop();
    summarize();
  end
endmodule
